// >>> shared/pwc_pkg.sv
// pulse width capture timer: shared constants, types and decode helpers
// assumes a single clock domain; this file holds no state or processes

package pwc_pkg;

  // ----------------------------------------------------------------
  // counter and field geometry
  // ----------------------------------------------------------------
  localparam int COUNT_WIDTH_DEF = 16;
  localparam int PRI_REG_WIDTH   = 8;
  localparam int PRI_LSB         = 0;
  localparam int PRI_MSB         = 3;
  localparam int SRC_CAP         = 0;
  localparam int SRC_OVF         = 1;
  localparam int SRC_COUNT       = 2;

  // ----------------------------------------------------------------
  // encodings and values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [3:0] PRI_OFF   = 4'h0;
  localparam logic       RST_CLEAR_ON_CAP = 1'b0;
  localparam logic       RST_LOCAL_IE     = 1'b0;
  localparam logic [1:0] RST_EDGE_SEL     = EDGE_NONE;

  // module operating state
  typedef enum logic [1:0] {
    MODE_STOPPED,
    MODE_IDLE,
    MODE_RUN
  } pwc_mode_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // edge decode against the selected polarity
  function automatic logic pwc_edge_hit(input logic [1:0] sel,
                                        input logic       prev,
                                        input logic       cur);
    pwc_edge_hit = ((sel == EDGE_RISE || sel == EDGE_BOTH) && !prev && cur) ||
                   ((sel == EDGE_FALL || sel == EDGE_BOTH) && prev && !cur);
  endfunction : pwc_edge_hit

  // priority level field of a priority register
  function automatic logic [3:0] pwc_level(input logic [PRI_REG_WIDTH-1:0] r);
    pwc_level = r[PRI_MSB:PRI_LSB];
  endfunction : pwc_level

endpackage : pwc_pkg

// >>> hdl/pwc_edge_detect.sv
// pulse width capture timer: edge detector for the capture pin
// assumes the pin is already synchronous to ref_clk

`timescale 1ns/1ps

module pwc_edge_detect
  import pwc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            edge_pulse
);

  // ----------------------------------------------------------------
  // previous pin level
  // ----------------------------------------------------------------
  logic prev;
  logic primed;

  // primed blocks a false edge from the reset value of prev
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev   <= 1'b0;
      primed <= 1'b0;
    end else if (clk_en) begin
      prev   <= pin;
      primed <= 1'b1;
    end
  end

  // one-cycle pulse in the cycle the pin differs from its last level
  assign edge_pulse = primed && pwc_edge_hit(edge_sel, prev, pin);

endmodule : pwc_edge_detect

// >>> hdl/pwc_irq_gate.sv
// pulse width capture timer: interrupt acceptance gate
// assumes request flags and enables are all steady flip-flop levels

`timescale 1ns/1ps

module pwc_irq_gate
  import pwc_pkg::*;
(
  input  wire logic [SRC_COUNT-1:0]     request_flag,
  input  wire logic [SRC_COUNT-1:0]     source_request_enable,
  input  wire logic [SRC_COUNT-1:0]     peripheral_enable,
  input  wire logic                     global_int_enable,
  input  wire logic [PRI_REG_WIDTH-1:0] cap_priority_reg,
  input  wire logic [PRI_REG_WIDTH-1:0] ovf_priority_reg,
  output logic                          deliver,
  output logic [3:0]                    level,
  output logic                          source
);

  // ----------------------------------------------------------------
  // per-source acceptance
  // ----------------------------------------------------------------
  wire [3:0] cap_lvl = pwc_level(cap_priority_reg);
  wire [3:0] ovf_lvl = pwc_level(ovf_priority_reg);

  // level zero keeps a source off, as a priority of none
  wire cap_ok = global_int_enable && request_flag[SRC_CAP] &&
                source_request_enable[SRC_CAP] && peripheral_enable[SRC_CAP] &&
                cap_lvl != PRI_OFF;
  wire ovf_ok = global_int_enable && request_flag[SRC_OVF] &&
                source_request_enable[SRC_OVF] && peripheral_enable[SRC_OVF] &&
                ovf_lvl != PRI_OFF;

  // capture wins a tie, since it carries the measured value
  wire pick_ovf = ovf_ok && (!cap_ok || ovf_lvl > cap_lvl);

  assign deliver = cap_ok || ovf_ok;
  assign level   = pick_ovf ? ovf_lvl : (cap_ok ? cap_lvl : PRI_OFF);
  assign source  = pick_ovf;

endmodule : pwc_irq_gate

// >>> hdl/pwc_timer.sv
// pulse width capture timer: free-running counter, capture hold,
// request flags, interrupt gate and module stop control
// assumes all inputs synchronous to ref_clk; configuration arrives as
// write strobes with their data on plain ports
//
// Functional notes
// - counter advances by one each enabled clock with no outside event
// - selected pin edge copies the running count into the hold register
// - each selected pin edge raises a capture request
// - each counter overflow raises a separate overflow request
// - capture and overflow requests are made and enabled independently
// - edge select offers rising, falling and both edges
// - optional clear of the counter on capture, restarting from zero
// - interrupt reaches processor only when all enabling conditions hold
// - maskable requests accepted only while the global bit is one
// - a peripheral request sets its request flag to one
// - priority level is bits three to zero of the priority register
// - request enable bits permit or block each source individually
// - timer has its own local enables for each request
// - the timer can be stopped on its own to save power
// - the timer leaves reset in the stopped state
// - while stopped, config writes are ignored and count and hold reads return zero

`timescale 1ns/1ps

module pwc_timer
  import pwc_pkg::*;
#(
  parameter int COUNT_WIDTH = COUNT_WIDTH_DEF
)(
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire logic                     capture_pin,
  input  wire logic                     stop_wr,
  input  wire logic                     stop_value,
  input  wire logic                     cfg_wr,
  input  wire logic                     cfg_count_enable,
  input  wire logic [1:0]               cfg_edge_select,
  input  wire logic                     cfg_clear_on_capture,
  input  wire logic                     cfg_capture_ie,
  input  wire logic                     cfg_overflow_ie,
  input  wire logic [SRC_COUNT-1:0]     flag_clear,
  input  wire logic                     global_int_enable,
  input  wire logic [SRC_COUNT-1:0]     source_request_enable,
  input  wire logic [PRI_REG_WIDTH-1:0] capture_priority_reg,
  input  wire logic [PRI_REG_WIDTH-1:0] overflow_priority_reg,
  output logic                          module_stopped,
  output logic [COUNT_WIDTH-1:0]        running_count,
  output logic [COUNT_WIDTH-1:0]        capture_hold,
  output logic [SRC_COUNT-1:0]          request_flag,
  output logic                          irq_out,
  output logic [3:0]                    irq_level,
  output logic                          irq_source
);

  // ----------------------------------------------------------------
  // state and configuration storage
  // ----------------------------------------------------------------
  pwc_mode_t              mode;
  pwc_mode_t              next_mode;
  logic [COUNT_WIDTH-1:0] count_value;
  logic [COUNT_WIDTH-1:0] next_count;
  logic [COUNT_WIDTH-1:0] hold_value;
  logic [1:0]             edge_sel;
  logic                   clear_sel;
  logic                   cap_ie;
  logic                   ovf_ie;
  logic [SRC_COUNT-1:0]   next_flag;
  logic                   edge_pulse;
  logic                   gate_deliver;
  logic [3:0]             gate_level;
  logic                   gate_source;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire stopped   = (mode == MODE_STOPPED);
  wire running   = (mode == MODE_RUN);
  wire next_stopped = (next_mode == MODE_STOPPED);
  wire cfg_take  = cfg_wr && !stopped;
  wire at_max    = (count_value == {COUNT_WIDTH{1'b1}});
  wire wrap_evt  = running && at_max;
  wire cap_event = edge_pulse && !stopped;
  wire cap_clear = cap_event && clear_sel;

  // local enables gate each request on its own
  wire [SRC_COUNT-1:0] flag_set = {wrap_evt && ovf_ie, cap_event && cap_ie};

  // ----------------------------------------------------------------
  // edge detection on the capture pin
  // ----------------------------------------------------------------
  pwc_edge_detect u_edge (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .pin        (capture_pin),
    .edge_sel   (edge_sel),
    .edge_pulse (edge_pulse)
  );

  // ----------------------------------------------------------------
  // module state: stopped, idle, running
  // ----------------------------------------------------------------
  // a cancel and a config write together: config is lost, module goes to idle
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_STOPPED: begin
        if (stop_wr && !stop_value) begin
          next_mode = MODE_IDLE;
        end
      end
      MODE_IDLE, MODE_RUN: begin
        if (stop_wr && stop_value) begin
          next_mode = MODE_STOPPED;
        end else if (cfg_take) begin
          next_mode = cfg_count_enable ? MODE_RUN : MODE_IDLE;
        end
      end
      default: begin
        next_mode = MODE_STOPPED;
      end
    endcase
  end

  // stop is the state after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= MODE_STOPPED;
    end else if (clk_en) begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // configuration bits, locked while stopped
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edge_sel  <= RST_EDGE_SEL;
      clear_sel <= RST_CLEAR_ON_CAP;
      cap_ie    <= RST_LOCAL_IE;
      ovf_ie    <= RST_LOCAL_IE;
    end else if (clk_en && cfg_take) begin
      edge_sel  <= cfg_edge_select;
      clear_sel <= cfg_clear_on_capture;
      cap_ie    <= cfg_capture_ie;
      ovf_ie    <= cfg_overflow_ie;
    end
  end

  // ----------------------------------------------------------------
  // running counter
  // ----------------------------------------------------------------
  // clear on capture beats increment; overflow wraps through zero
  assign next_count = cap_clear ? {COUNT_WIDTH{1'b0}} :
                      running   ? count_value + 1'b1 :
                                  count_value;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_value <= {COUNT_WIDTH{1'b0}};
    end else if (clk_en) begin
      count_value <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // capture hold
  // ----------------------------------------------------------------
  // takes the pre-clear value, so clear and capture can share an edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_value <= {COUNT_WIDTH{1'b0}};
    end else if (clk_en && cap_event) begin
      hold_value <= count_value;
    end
  end

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // a set in the clearing cycle wins, so no event is dropped
  assign next_flag = (request_flag & ~flag_clear) | flag_set;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      request_flag <= {SRC_COUNT{1'b0}};
    end else if (clk_en) begin
      request_flag <= next_flag;
    end
  end

  // ----------------------------------------------------------------
  // interrupt gate
  // ----------------------------------------------------------------
  pwc_irq_gate u_gate (
    .request_flag          (request_flag),
    .source_request_enable (source_request_enable),
    .peripheral_enable     ({ovf_ie, cap_ie}),
    .global_int_enable     (global_int_enable),
    .cap_priority_reg      (capture_priority_reg),
    .ovf_priority_reg      (overflow_priority_reg),
    .deliver               (gate_deliver),
    .level                 (gate_level),
    .source                (gate_source)
  );

  // registered so the processor sees a clean level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_out    <= 1'b0;
      irq_level  <= PRI_OFF;
      irq_source <= 1'b0;
    end else if (clk_en) begin
      irq_out    <= gate_deliver;
      irq_level  <= gate_level;
      irq_source <= gate_source;
    end
  end

  // ----------------------------------------------------------------
  // read views
  // ----------------------------------------------------------------
  // stopped module shows zero instead of its contents; keyed to the next
  // state so the views blank on the same edge that module_stopped rises
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      module_stopped <= 1'b1;
      running_count  <= {COUNT_WIDTH{1'b0}};
      capture_hold   <= {COUNT_WIDTH{1'b0}};
    end else if (clk_en) begin
      module_stopped <= next_stopped;
      running_count  <= next_stopped ? {COUNT_WIDTH{1'b0}} : next_count;
      capture_hold   <= next_stopped ? {COUNT_WIDTH{1'b0}} :
                        (cap_event ? count_value : hold_value);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // counter steps by one unless a capture clears it
  property p_count_step;
    clk_en && running && !cap_clear |=> count_value == $past(count_value) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance by one");

  // hold takes the value the counter had on the edge
  property p_capture_value;
    clk_en && cap_event |=> hold_value == $past(count_value);
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("hold value differs from counter at capture");

  // enabled capture raises its flag on the next edge
  property p_capture_flag;
    clk_en && cap_event && cap_ie |=> request_flag[SRC_CAP];
  endproperty
  a_capture_flag: assert property (p_capture_flag)
    else $error("capture flag not set");

  // overflow raises its flag and the counter restarts at zero
  property p_overflow;
    clk_en && wrap_evt && ovf_ie |=> request_flag[SRC_OVF] && count_value == '0;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow flag or wrap missing");

  // disabled capture leaves its flag clear
  property p_capture_blocked;
    clk_en && !cap_ie && !request_flag[SRC_CAP] |=> !request_flag[SRC_CAP];
  endproperty
  a_capture_blocked: assert property (p_capture_blocked)
    else $error("capture flag set while locally disabled");

  // any pin change catches with both edges selected
  property p_both_edges;
    clk_en && $past(clk_en) && !$past(rst) && edge_sel == EDGE_BOTH &&
      capture_pin != $past(capture_pin) |-> edge_pulse;
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("pin transition missed in both-edge mode");

  // clear on capture restarts the count, hold keeps the old value
  property p_clear_capture;
    clk_en && cap_clear |=> count_value == '0 && hold_value == $past(count_value);
  endproperty
  a_clear_capture: assert property (p_clear_capture)
    else $error("capture and clear ordering broken");

  // no delivery while the global bit is low
  property p_global_mask;
    clk_en && !global_int_enable |=> !irq_out;
  endproperty
  a_global_mask: assert property (p_global_mask)
    else $error("interrupt delivered with global bit low");

  // all conditions met gives delivery one cycle later
  property p_deliver;
    clk_en && global_int_enable && request_flag[SRC_CAP] &&
      source_request_enable[SRC_CAP] && cap_ie &&
      pwc_level(capture_priority_reg) != PRI_OFF |=> irq_out;
  endproperty
  a_deliver: assert property (p_deliver)
    else $error("enabled capture request not delivered");

  // stopped state right after reset, with the hold read at zero
  property p_reset_stop;
    $fell(rst) |-> mode == MODE_STOPPED && module_stopped && capture_hold == '0;
  endproperty
  a_reset_stop: assert property (p_reset_stop)
    else $error("module not stopped after reset");

  // writes while stopped leave the configuration alone
  property p_stop_lock;
    clk_en && stopped && cfg_wr |=> $stable(edge_sel) && $stable(clear_sel) &&
      $stable(cap_ie) && $stable(ovf_ie);
  endproperty
  a_stop_lock: assert property (p_stop_lock)
    else $error("configuration changed while stopped");

  // read views stay at zero for as long as the module reports stopped
  property p_stop_reads;
    module_stopped |-> running_count == '0 && capture_hold == '0;
  endproperty
  a_stop_reads: assert property (p_stop_reads)
    else $error("register contents visible while stopped");

  // ----------------------------------------------------------------
  // coverage of main scenarios
  // ----------------------------------------------------------------
  c_clear_capture: cover property (clk_en && cap_clear);
  c_overflow:      cover property (clk_en && wrap_evt && ovf_ie);
  c_both_edges:    cover property (clk_en && cap_event && edge_sel == EDGE_BOTH);
  c_irq:           cover property (irq_out && irq_source);

endmodule : pwc_timer

// >>> tb/pwc_pulse_src.sv
// pulse width capture timer bench: model of the pulse source on the capture pin
// assumes the bench raises start for one cycle; the pin rises at the edge that samples it

`timescale 1ns/1ps

// ----------------------------------------------------------------
// pulse source
// ----------------------------------------------------------------
module pwc_pulse_src (
  input  wire logic        ref_clk,
  input  wire logic        start,
  input  wire logic [15:0] hi_cycles,
  output logic             pin
);
  logic [15:0] left;

  // pin idles low; a start while a pulse runs is ignored, so widths never stretch
  initial begin
    pin  = 1'b0;
    left = 16'h0000;
  end

  // high for exactly hi_cycles clock periods, then back low
  always @(posedge ref_clk) begin
    if (start && left == 16'h0000) begin
      pin  <= 1'b1;
      left <= hi_cycles;
    end else if (left == 16'h0001) begin
      pin  <= 1'b0;
      left <= 16'h0000;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
endmodule : pwc_pulse_src

// >>> tb/pwc_timer_tb.sv
// pulse width capture timer bench: gate table, then stop, overflow and width tests
// assumes a narrow counter so that wrap happens within a few hundred cycles

`timescale 1ns/1ps

module pwc_timer_tb;
  import pwc_pkg::*;

  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam int W  = 8;
  localparam int PW = 300;

  typedef struct packed {
    logic [1:0] sel; logic gie; logic [1:0] sre; logic ie; logic [7:0] pri;
    logic rise; logic fall; logic irq; logic [3:0] lvl;
  } pwc_row_t;

  // edge select, mask, enables and priority against flags, delivery and level
  localparam pwc_row_t ROWS [8] = '{
    '{EDGE_BOTH, 1'b1, 2'h1, 1'b1, 8'hF5, 1'b1, 1'b1, 1'b1, 4'h5},
    '{EDGE_RISE, 1'b1, 2'h1, 1'b1, 8'h02, 1'b1, 1'b0, 1'b1, 4'h2},
    '{EDGE_FALL, 1'b1, 2'h1, 1'b1, 8'h02, 1'b0, 1'b1, 1'b0, 4'h0},
    '{EDGE_NONE, 1'b1, 2'h1, 1'b1, 8'h02, 1'b0, 1'b0, 1'b0, 4'h0},
    '{EDGE_BOTH, 1'b0, 2'h1, 1'b1, 8'h02, 1'b1, 1'b1, 1'b0, 4'h0},
    '{EDGE_BOTH, 1'b1, 2'h2, 1'b1, 8'h02, 1'b1, 1'b1, 1'b0, 4'h0},
    '{EDGE_BOTH, 1'b1, 2'h1, 1'b0, 8'h02, 1'b0, 1'b0, 1'b0, 4'h0},
    '{EDGE_BOTH, 1'b1, 2'h1, 1'b1, 8'hF0, 1'b1, 1'b1, 1'b0, 4'h0}
  };

  logic                 ref_clk, rst, clk_en, capture_pin, stop_wr, stop_value, cfg_wr;
  logic                 cfg_count_enable, cfg_clear_on_capture, cfg_capture_ie, cfg_overflow_ie;
  logic [1:0]           cfg_edge_select, flag_clear, source_request_enable;
  logic                 global_int_enable, module_stopped, irq_out, irq_source, start;
  logic [7:0]           capture_priority_reg, overflow_priority_reg;
  logic [W-1:0]         running_count, capture_hold;
  logic [SRC_COUNT-1:0] request_flag;
  logic [3:0]           irq_level;
  logic [15:0]          hi_cycles, sw_width;
  int                   n_fail, compares, n_ovf;

  pwc_timer #(.COUNT_WIDTH(W)) i_pwc_timer (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .capture_pin(capture_pin),
    .stop_wr(stop_wr), .stop_value(stop_value), .cfg_wr(cfg_wr),
    .cfg_count_enable(cfg_count_enable), .cfg_edge_select(cfg_edge_select),
    .cfg_clear_on_capture(cfg_clear_on_capture), .cfg_capture_ie(cfg_capture_ie),
    .cfg_overflow_ie(cfg_overflow_ie), .flag_clear(flag_clear),
    .global_int_enable(global_int_enable), .source_request_enable(source_request_enable),
    .capture_priority_reg(capture_priority_reg), .overflow_priority_reg(overflow_priority_reg),
    .module_stopped(module_stopped), .running_count(running_count),
    .capture_hold(capture_hold), .request_flag(request_flag), .irq_out(irq_out),
    .irq_level(irq_level), .irq_source(irq_source));

  pwc_pulse_src i_pwc_pulse_src (
    .ref_clk(ref_clk), .start(start), .hi_cycles(hi_cycles), .pin(capture_pin));

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // inputs move 1 ns after the edge so the design samples settled values
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic chk_bit(input logic got, input logic want);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk_val

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic rst_seq(input int n);
    rst = 1'b1;
    repeat (n) tick;
    rst = 1'b0;
  endtask : rst_seq

  task automatic stop_set(input logic v);
    stop_wr    = 1'b1;
    stop_value = v;
    tick;
    stop_wr    = 1'b0;
  endtask : stop_set

  task automatic cfg(input logic en, input logic [1:0] sel, input logic clr, cie, oie);
    cfg_count_enable     = en;
    cfg_edge_select      = sel;
    cfg_clear_on_capture = clr;
    cfg_capture_ie       = cie;
    cfg_overflow_ie      = oie;
    cfg_wr               = 1'b1;
    tick;
    cfg_wr               = 1'b0;
  endtask : cfg

  task automatic results;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // a hang is cut after nearly six times the expected run
  initial begin
    #100000;
    n_fail++;
    results;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, clk_en} = 2'b11;
    {stop_wr, stop_value, cfg_wr, cfg_count_enable, cfg_clear_on_capture} = 5'h00;
    {cfg_capture_ie, cfg_overflow_ie, global_int_enable, start} = 4'h0;
    {cfg_edge_select, flag_clear, source_request_enable} = 6'h00;
    {capture_priority_reg, overflow_priority_reg, hi_cycles} = 32'h0000_0000;
    n_fail = 0;
    compares = 0;
    n_ovf = 0;
    repeat (6) tick;
    rst = 1'b0;
    // gate table: one capture pulse per row, flags read after rise and after fall
    stop_set(1'b0);
    foreach (ROWS[i]) begin
      global_int_enable     = ROWS[i].gie;
      source_request_enable = ROWS[i].sre;
      capture_priority_reg  = ROWS[i].pri;
      {flag_clear, start, hi_cycles} = {2'h3, 1'b1, 16'h0006};
      cfg(1'b0, ROWS[i].sel, 1'b0, ROWS[i].ie, 1'b0);
      {flag_clear, start} = 3'h0;
      repeat (2) tick;
      chk_bit(request_flag[0], ROWS[i].rise);
      chk_bit(irq_out, ROWS[i].irq);
      chk_val(16'(irq_level), 16'(ROWS[i].lvl));
      flag_clear = 2'h1;
      tick;
      flag_clear = 2'h0;
      repeat (5) tick;
      chk_bit(request_flag[0], ROWS[i].fall);
    end
    done("gate table");
    // module stop: out of reset stopped, config and capture refused, reads zero
    rst_seq(2);
    chk_bit(module_stopped, 1'b1);
    chk_val(16'({running_count, request_flag, irq_out}), 16'h0000);
    {global_int_enable, source_request_enable, capture_priority_reg} = {3'h7, 8'h01};
    {start, hi_cycles} = {1'b1, 16'h0003};
    cfg(1'b1, EDGE_BOTH, 1'b0, 1'b1, 1'b1);
    start = 1'b0;
    repeat (6) tick;
    chk_val(16'({running_count, request_flag}), 16'h0000);
    stop_set(1'b0);
    chk_bit(module_stopped, 1'b0);
    repeat (3) tick;
    chk_val(16'(running_count), 16'h0000);
    cfg(1'b1, EDGE_BOTH, 1'b0, 1'b1, 1'b1);
    repeat (20) tick;
    stop_set(1'b1);
    chk_bit(module_stopped, 1'b1);
    chk_val(16'(running_count), 16'h0000);
    {start, hi_cycles} = {1'b1, 16'h0003};
    tick;
    start = 1'b0;
    repeat (5) tick;
    stop_set(1'b0);
    chk_val(16'({capture_hold, request_flag}), 16'h0000);
    done("module stop");
    // free run up to wrap, overflow request on its own
    rst_seq(2);
    stop_set(1'b0);
    {source_request_enable, capture_priority_reg, overflow_priority_reg} = {2'h2, 16'h0703};
    cfg(1'b1, EDGE_NONE, 1'b0, 1'b1, 1'b1);
    repeat (99) tick;
    chk_val(16'(running_count), 16'd99);
    repeat (156) tick;
    chk_val(16'({running_count, request_flag}), 16'h03FC);
    tick;
    chk_val(16'({running_count, request_flag}), 16'h0002);
    tick;
    chk_val(16'({irq_out, irq_source, irq_level}), 16'h0033);
    tick;
    chk_val(16'(running_count), 16'h0002);
    clk_en = 1'b0;
    repeat (5) tick;
    chk_val(16'(running_count), 16'h0002);
    clk_en = 1'b1;
    tick;
    chk_val(16'(running_count), 16'h0003);
    done("overflow");
    // pulse width: capture both edges, clear on capture, software counts wraps
    rst_seq(2);
    stop_set(1'b0);
    cfg(1'b1, EDGE_BOTH, 1'b1, 1'b1, 1'b1);
    repeat (9) tick;
    {start, hi_cycles} = {1'b1, 16'(PW)};
    tick;
    start = 1'b0;
    tick;
    chk_val(16'(capture_hold), 16'd10);
    chk_val(16'(running_count), 16'h0000);
    flag_clear = 2'h1;
    tick;
    for (int k = 0; k < 1000 && request_flag[0] !== 1'b1; k++) begin
      flag_clear = {request_flag[1] === 1'b1, 1'b0};
      if (request_flag[1] === 1'b1) n_ovf++;
      tick;
    end
    flag_clear = 2'h0;
    chk_bit(request_flag[0], 1'b1);
    chk_val(16'(capture_hold), 16'((PW - 1) % 256));
    chk_val(16'(n_ovf), 16'h0001);
    sw_width = 16'(n_ovf * 256) + 16'(capture_hold) + 16'h0001;
    chk_val(sw_width, 16'(PW));
    done("pulse width");
    results;
  end
endmodule : pwc_timer_tb
